// ---- logic/card_host.v ----
`include "card_port_map.vh"
module card_host #(
	parameter LOAD_WINDOW_CYC = `CYC_MAX(`ATTR_LOAD_WINDOW_NS),
	parameter PROGRAM_CYC = `CYC_MIN(`ATTR_PROGRAM_NS),
	parameter TW = 24
) (
	// Clock and reset.
	input wire sys_clk,
	input wire nrst,
	// Request side.
	input wire req_valid,
	output wire req_ready,
	input wire req_write,
	input wire req_attr,
	input wire req_page_more,
	input wire [1:0] req_size,
	input wire [`ADDR_W-1:0] req_addr,
	input wire [15:0] req_wdata,
	// Answer side.
	output reg rsp_valid,
	output reg [15:0] rsp_rdata,
	output reg rsp_refused,
	output reg attr_busy,
	output reg protected_q,
	output reg [1:0] battery_q,
	// Card pins.
	output reg [`ADDR_W-1:0] card_addr,
	output reg attr_select_n,
	output reg low_byte_enable_n,
	output reg high_byte_enable_n,
	output reg output_enable_n,
	output reg write_enable_n,
	output reg [15:0] card_dout,
	output reg card_doe_n,
	input wire [15:0] card_din,
	input wire write_protect,
	input wire battery_status_first,
	input wire battery_status_second
);
	// ****************************************************
	// States, one-hot.
	// ****************************************************
	localparam S_IDLE = 6'h01;
	localparam S_SETUP = 6'h02;
	localparam S_STROBE = 6'h04;
	localparam S_RECOVER = 6'h08;
	localparam S_PAGE = 6'h10;
	localparam S_PROGRAM = 6'h20;

	reg [5:0] state_q;
	reg write_q, attr_q, more_q;
	reg [1:0] size_q;
	reg [5:0] page_count_q;
	reg [TW-1:0] tval;
	reg tload;
	wire tdone;

	cycle_timer #(.W(TW)) u_timer (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.load(tload),
		.value(tval),
		.done(tdone)
	);

	// Converts a figure for this access kind to a timer load value.
	function [TW-1:0] phase_cyc;
		input integer cyc;
		begin
			phase_cyc = (cyc < 1) ? {{(TW-1){1'b0}}, 1'b1} : cyc[TW-1:0];
		end
	endfunction

	// A new request may be taken in idle, or in the page window for a following attribute byte.
	wire page_ok = (state_q == S_PAGE) && req_attr && req_write &&
		(req_addr[`PAGE_HI:`PAGE_LO] == card_addr[`PAGE_HI:`PAGE_LO]) &&
		(page_count_q < `PAGE_BYTES);
	assign req_ready = (state_q == S_IDLE) || page_ok;
	wire take = req_valid && req_ready;
	wire reject = req_write && write_protect;

	// ****************************************************
	// Sequencer.
	// ****************************************************
	always @* begin
		tload = 1'b0;
		tval = {TW{1'b0}};
		case (state_q)
			S_IDLE, S_PAGE: begin
				if (take && !reject) begin
					tload = 1'b1;
					tval = phase_cyc(req_attr ? `CYC_MIN(`ATTR_SETUP_NS) : `CYC_MIN(`MAIN_SETUP_NS));
				end else if (state_q == S_PAGE && tdone && !take) begin
					// The card starts programming a little after the window closes, so wait that out too.
					tload = 1'b1;
					tval = phase_cyc(PROGRAM_CYC + `CYC_MIN(`ATTR_SETUP_NS) + `PAGE_MARGIN_CYC);
				end
			end
			S_SETUP: begin
				if (tdone) begin
					tload = 1'b1;
					tval = phase_cyc(attr_q ? (write_q ? `CYC_MIN(`ATTR_WE_PULSE_NS) : `CYC_MIN(`ATTR_CYCLE_NS))
						: (write_q ? `CYC_MIN(`MAIN_WE_PULSE_NS) : `CYC_MIN(`MAIN_CYCLE_NS)));
				end
			end
			S_STROBE: begin
				if (tdone) begin
					tload = 1'b1;
					tval = phase_cyc(attr_q ? `CYC_MIN(`ATTR_HOLD_NS) : `CYC_MIN(`MAIN_RECOVERY_NS));
				end
			end
			S_RECOVER: begin
				if (tdone && attr_q && write_q) begin
					tload = 1'b1;
					// The window is shortened so the next write enable falls inside the card's load time.
					tval = more_q ? phase_cyc(LOAD_WINDOW_CYC - `CYC_MIN(`ATTR_HOLD_NS) -
						`CYC_MIN(`ATTR_SETUP_NS) - `PAGE_MARGIN_CYC)
						: phase_cyc(LOAD_WINDOW_CYC + PROGRAM_CYC);
				end
			end
			default: ;
		endcase
	end

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= S_IDLE;
			write_q <= 1'b0;
			attr_q <= 1'b0;
			more_q <= 1'b0;
			size_q <= `SIZE_WORD;
			page_count_q <= 6'h00;
			card_addr <= {`ADDR_W{1'b0}};
			attr_select_n <= 1'b1;
			low_byte_enable_n <= 1'b1;
			high_byte_enable_n <= 1'b1;
			output_enable_n <= 1'b1;
			write_enable_n <= 1'b1;
			card_dout <= 16'h0000;
			card_doe_n <= 1'b1;
			rsp_valid <= 1'b0;
			rsp_rdata <= 16'h0000;
			rsp_refused <= 1'b0;
			attr_busy <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			rsp_refused <= 1'b0;
			case (state_q)
				S_IDLE, S_PAGE: begin
					if (take && reject) begin
						rsp_valid <= 1'b1;
						rsp_refused <= 1'b1;
					end else if (take) begin
						// Address and data go out before any strobe falls.
						write_q <= req_write;
						attr_q <= req_attr;
						more_q <= req_page_more && (page_count_q < `PAGE_BYTES - 1);
						size_q <= req_attr ? `SIZE_EVEN_BYTE : req_size;
						card_addr <= req_attr ? {req_addr[`ADDR_W-1:1], 1'b0} : req_addr;
						attr_select_n <= !req_attr;
						card_dout <= req_attr ? {8'h00, req_wdata[7:0]} : req_wdata;
						card_doe_n <= !req_write;
						page_count_q <= (state_q == S_PAGE) ? page_count_q + 6'h01 : 6'h01;
						state_q <= S_SETUP;
					end else if (state_q == S_PAGE && tdone) begin
						attr_busy <= 1'b1;
						state_q <= S_PROGRAM;
					end
				end
				S_SETUP: begin
					// Byte enables pick the lane width; write enable falls with them so the overlap bounds the write.
					if (tdone) begin
						low_byte_enable_n <= (size_q == `SIZE_ODD_HIGH);
						high_byte_enable_n <= (size_q != `SIZE_WORD) && (size_q != `SIZE_ODD_HIGH);
						write_enable_n <= !write_q;
						output_enable_n <= write_q;
						state_q <= S_STROBE;
					end
				end
				S_STROBE: begin
					if (tdone) begin
						// Rising write enable latches attribute data; read data sampled at strobe end.
						write_enable_n <= 1'b1;
						output_enable_n <= 1'b1;
						if (!write_q) begin
							case (size_q)
								`SIZE_WORD: rsp_rdata <= attr_q ? {8'h00, card_din[7:0]} : card_din;
								`SIZE_ODD_HIGH: rsp_rdata <= {8'h00, card_din[15:8]};
								default: rsp_rdata <= {8'h00, card_din[7:0]};
							endcase
						end
						state_q <= S_RECOVER;
					end
				end
				S_RECOVER: begin
					if (tdone) begin
						// Dropping both enables floats the card bus.
						low_byte_enable_n <= 1'b1;
						high_byte_enable_n <= 1'b1;
						card_doe_n <= 1'b1;
						rsp_valid <= 1'b1;
						if (attr_q && write_q) begin
							attr_busy <= !more_q;
							state_q <= more_q ? S_PAGE : S_PROGRAM;
						end else begin
							state_q <= S_IDLE;
						end
					end
				end
				S_PROGRAM: begin
					// The card programs on its own; nothing is issued until the window has passed.
					if (tdone) begin
						attr_busy <= 1'b0;
						state_q <= S_IDLE;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// ****************************************************
	// Card status pins, registered.
	// ****************************************************
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			protected_q <= 1'b0;
			battery_q <= `BATT_LOST;
		end else begin
			protected_q <= write_protect;
			battery_q <= {battery_status_first, battery_status_second};
		end
	end
endmodule

// ---- logic/card_port_map.vh ----
`ifndef CARD_PORT_MAP_VH
`define CARD_PORT_MAP_VH
// ****************************************************
// Timing figures at the 250 MHz system clock.
// ****************************************************
`define CLK_PERIOD_NS 4
`define MAIN_CYCLE_NS 150
`define MAIN_WE_PULSE_NS 80
`define MAIN_SETUP_NS 20
`define MAIN_RECOVERY_NS 20
`define ATTR_CYCLE_NS 300
`define ATTR_SETUP_NS 40
`define ATTR_WE_PULSE_NS 170
`define ATTR_HOLD_NS 40
`define ATTR_LOAD_WINDOW_NS 30000
`define ATTR_PROGRAM_NS 10000000
// Whole nanoseconds keep the ten millisecond figure inside 32-bit arithmetic.
`define CYC_MIN(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_MAX(ns) ((ns) / `CLK_PERIOD_NS)
// Cycles lost between the window's last edge and the falling write enable.
`define PAGE_MARGIN_CYC 3
// ****************************************************
// Access kinds and widths.
// ****************************************************
`define ADDR_W 22
`define PAGE_BYTES 32
`define PAGE_LO 6
`define PAGE_HI 13
`define SIZE_WORD 2'h0
`define SIZE_EVEN_BYTE 2'h1
`define SIZE_ODD_HIGH 2'h2
`define BATT_GOOD 2'h3
`define BATT_REPLACE 2'h2
`define BATT_LOST 2'h0
`endif

// ---- logic/cycle_timer.v ----
`include "card_port_map.vh"
// ****************************************************
// Down counter used to time each phase of a card cycle.
// ****************************************************
module cycle_timer #(
	parameter W = 24
) (
	// Clock and reset.
	input wire sys_clk,
	input wire nrst,
	// Load and status.
	input wire load,
	input wire [W-1:0] value,
	output wire done
);
	reg [W-1:0] count_q;

	// Loading wins over counting so a new phase always starts cleanly.
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			count_q <= {W{1'b0}};
		end else if (load) begin
			count_q <= value;
		end else if (count_q != {W{1'b0}}) begin
			count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
		end
	end

	// Done does not look at load, so a load made on done cannot form a loop.
	assign done = (count_q == {W{1'b0}});
endmodule

// ---- tb/card_host_chk.sv ----
module card_host_chk (
	// Clock and reset.
	input wire sys_clk,
	input wire nrst,
	// Card pins and answer flags.
	input wire [21:0] card_addr,
	input wire attr_select_n,
	input wire low_byte_enable_n,
	input wire high_byte_enable_n,
	input wire output_enable_n,
	input wire write_enable_n,
	input wire card_doe_n,
	input wire rsp_valid,
	input wire rsp_refused,
	input wire attr_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	wire idle = low_byte_enable_n && high_byte_enable_n;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// A strobe in standby would go unseen by the card, so each must sit inside a selected cycle.
	a_strobe_has_enable: assert property (!(write_enable_n && output_enable_n) |-> !idle)
		else $error("strobe outside enable");
	a_write_keeps_oe: assert property (!write_enable_n |-> output_enable_n && !card_doe_n)
		else $error("write without drive");
	a_read_keeps_we: assert property (!output_enable_n |-> write_enable_n && card_doe_n)
		else $error("read while driving");
	a_write_addr_held: assert property (!write_enable_n |=> write_enable_n || $stable(card_addr))
		else $error("address moved in write");
	a_attr_even_low: assert property (!attr_select_n && !write_enable_n |-> !card_addr[0] && !low_byte_enable_n)
		else $error("attribute write odd");
	a_no_attr_in_prog: assert property (attr_busy |-> write_enable_n || attr_select_n)
		else $error("attribute write in program");
	a_refused_quiet: assert property (rsp_refused |-> rsp_valid && write_enable_n && $past(write_enable_n))
		else $error("refused write strobed");
	a_enables_last: assert property ($rose(low_byte_enable_n) |-> write_enable_n && output_enable_n)
		else $error("enable lifted first");
	a_release_idle: assert property ($rose(nrst) |-> write_enable_n && output_enable_n && idle)
		else $error("pins busy at reset");
	c_attr_write: cover property (!attr_select_n && !write_enable_n);
	c_refused: cover property (rsp_refused);
	c_program: cover property ($fell(attr_busy));
endmodule
bind card_host card_host_chk chk (.*);

// ---- tb/card_model.sv ----
module card_model (
	// Pins from the host.
	input wire [21:0] card_addr,
	input wire attr_select_n,
	input wire low_byte_enable_n,
	input wire high_byte_enable_n,
	input wire output_enable_n,
	input wire write_enable_n,
	input wire [15:0] card_dout,
	// Bus and status to the host.
	output logic [15:0] card_din,
	output wire write_protect,
	output wire battery_status_first,
	output wire battery_status_second,
	// Switch and cell set by the bench.
	input wire wp_sw,
	input wire [1:0] batt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] ram [0:255];
	logic [7:0] atr [0:255];
	logic [15:0] last = 16'h0000;
	wire [7:0] ix = card_addr[8:1];
	wire lo = !low_byte_enable_n;
	wire hi = !high_byte_enable_n;
	wire rd = !output_enable_n && write_enable_n;
	wire m = attr_select_n;
	assign write_protect = wp_sw;
	assign {battery_status_first, battery_status_second} = batt;
	initial for (int i = 0; i < 256; i++) begin
		ram[i] = 16'h0000;
		atr[i] = 8'h00;
	end
	// Floating lanes show the inverse of the last value so a stale copy is never read as data.
	always @* begin
		card_din = ~last;
		if (rd && m && lo && hi) card_din = ram[ix];
		if (rd && m && lo && !hi) card_din[7:0] = card_addr[0] ? ram[ix][15:8] : ram[ix][7:0];
		if (rd && m && !lo && hi) card_din[15:8] = ram[ix][15:8];
		if (rd && !m && lo && !card_addr[0]) card_din[7:0] = atr[ix];
	end
	// Data lands as the write strobe lifts, which closes the overlap with the enables.
	always @(posedge write_enable_n) begin
		last = card_dout;
		if (!wp_sw && m && lo && (hi || !card_addr[0])) ram[ix][7:0] = card_dout[7:0];
		if (!wp_sw && m && lo && !hi && card_addr[0]) ram[ix][15:8] = card_dout[7:0];
		if (!wp_sw && m && hi) ram[ix][15:8] = card_dout[15:8];
		if (!wp_sw && !m && lo && !card_addr[0]) atr[ix] = card_dout[7:0];
	end
	always @(posedge output_enable_n) last = card_din;
endmodule

// ---- tb/test_dual_width_memory_card_port.sv ----
`include "card_port_map.vh"
module test_dual_width_memory_card_port;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LOAD_W = 50;
	localparam int PROG_C = 200;
	logic sys_clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_attr = 1'b0;
	logic req_page_more = 1'b0, wp_sw = 1'b0, refused;
	logic [1:0] req_size = 2'h0, batt = 2'h3;
	logic [21:0] req_addr = 22'h000000;
	logic [15:0] req_wdata = 16'h0000, rd;
	wire req_ready, rsp_valid, rsp_refused, attr_busy, protected_q, attr_select_n, low_byte_enable_n;
	wire high_byte_enable_n, output_enable_n, write_enable_n, card_doe_n, write_protect;
	wire battery_status_first, battery_status_second;
	wire [1:0] battery_q;
	wire [21:0] card_addr;
	wire [15:0] rsp_rdata, card_dout, card_din;
	int errors = 0, n_checks = 0;
	card_host #(.LOAD_WINDOW_CYC(LOAD_W), .PROGRAM_CYC(PROG_C)) uut (.*);
	card_model card (.*);
	always #2 sys_clk = ~sys_clk;
	task automatic conclude;
		if (errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One request held until taken, then the answer is awaited under a bound.
	task automatic acc(input logic w, a, pm, input logic [1:0] sz, input logic [21:0] ad, input logic [15:0] wd);
		int n;
		{req_write, req_attr, req_page_more, req_size, req_addr, req_wdata} = {w, a, pm, sz, ad, wd};
		req_valid = 1'b1;
		for (n = 0; req_ready !== 1'b1; n++) begin
			if (n > 1000) chk(1'b0, 1'b1);
			if (n > 1000) conclude();
			@(negedge sys_clk);
		end
		@(negedge sys_clk);
		req_valid = 1'b0;
		for (n = 0; rsp_valid !== 1'b1; n++) begin
			if (n > 300) chk(1'b0, 1'b1);
			if (n > 300) conclude();
			@(negedge sys_clk);
		end
		rd = rsp_rdata;
		refused = rsp_refused;
		@(negedge sys_clk);
	endtask
	// The busy flag, counted over 600 cycles, must last its set length, load window included where it covers it.
	task automatic prog(input int exp);
		int b = 0;
		repeat (600) begin
			@(negedge sys_clk);
			b += attr_busy;
		end
		chk(b >= exp && b <= exp + 1, 1'b1);
	endtask
	task automatic s_main;
		acc(1, 0, 0, 2'h0, 22'h000011, 16'hA55A);
		acc(0, 0, 0, 2'h0, 22'h000010, 16'h0000);
		chk(rd, 16'hA55A);
		acc(1, 0, 0, 2'h1, 22'h000011, 16'h0077);
		acc(1, 0, 0, 2'h2, 22'h000010, 16'hBB00);
		acc(0, 0, 0, 2'h0, 22'h000010, 16'h0000);
		chk(rd, 16'hBB5A);
		acc(0, 0, 0, 2'h1, 22'h000011, 16'h0000);
		chk(rd[7:0], 8'hBB);
	endtask
	task automatic s_attr;
		// After a last byte the card waits out its load window, then programs; two busy cycles pass inside acc.
		acc(1, 1, 0, 2'h1, 22'h000101, 16'hFFC3);
		prog(LOAD_W + PROG_C - 1);
		acc(0, 1, 0, 2'h1, 22'h000100, 16'h0000);
		chk(rd[7:0], 8'hC3);
		acc(1, 1, 1, 2'h1, 22'h000102, 16'h0011);
		acc(1, 1, 0, 2'h1, 22'h000104, 16'h0022);
		prog(LOAD_W + PROG_C - 1);
		acc(0, 1, 0, 2'h1, 22'h000102, 16'h0000);
		chk(rd[7:0], 8'h11);
		acc(0, 1, 0, 2'h1, 22'h000104, 16'h0000);
		chk(rd[7:0], 8'h22);
		// A page byte with no follower lets the window lapse into the program wait.
		acc(1, 1, 1, 2'h1, 22'h000106, 16'h0033);
		prog(PROG_C + `CYC_MIN(`ATTR_SETUP_NS) + `PAGE_MARGIN_CYC + 1);
		acc(0, 1, 0, 2'h1, 22'h000106, 16'h0000);
		chk(rd[7:0], 8'h33);
	endtask
	task automatic s_protect;
		wp_sw = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk(protected_q, 1'b1);
		acc(1, 0, 0, 2'h0, 22'h000010, 16'h1234);
		chk(refused, 1'b1);
		acc(0, 0, 0, 2'h0, 22'h000010, 16'h0000);
		chk(rd, 16'hBB5A);
		wp_sw = 1'b0;
		repeat (3) @(negedge sys_clk);
		chk(protected_q, 1'b0);
		acc(1, 0, 0, 2'h0, 22'h000020, 16'h4321);
		chk(refused, 1'b0);
		acc(0, 0, 0, 2'h0, 22'h000020, 16'h0000);
		chk(rd, 16'h4321);
	endtask
	task automatic s_batt;
		logic [1:0] codes [3] = '{`BATT_GOOD, `BATT_REPLACE, `BATT_LOST};
		foreach (codes[i]) begin
			batt = codes[i];
			repeat (3) @(negedge sys_clk);
			chk(battery_q, codes[i]);
		end
	endtask
	// Reset for three cycles, then each scenario in turn.
	initial begin
		repeat (3) @(negedge sys_clk);
		nrst = 1'b1;
		s_main();
		s_attr();
		s_protect();
		s_batt();
		conclude();
	end
endmodule
